// [rtl/disc_eval_defs.vh]
// Constants of the two-channel discrepancy evaluation block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef DISC_EVAL_DEFS_VH
`define DISC_EVAL_DEFS_VH
// Register byte addresses.
`define A_CTRL 12'h000
`define A_TIME0 12'h004
`define A_TIME1 12'h008
`define A_STAT 12'h00C
`define A_MASK 12'h010
`define A_DIAG 12'h014
`define A_INPUT 12'h018
// Control fields, one byte per channel pair; bits 16 to 18 are module-wide.
`define F_IFTYPE 1:0
`define F_HOLD 2
`define F_ZTEST 3
`define F_CHEN 4
`define F_SCT 16
`define F_SUPINT 17
`define F_PASSCH 18
`define PAIR_LSB 8
// Interconnection types.
`define IF_ONE 2'h0
`define IF_EQU 2'h1
`define IF_NEQ 2'h2
// Reset value: pair 0 and 1 enabled, equivalent, hold, no zero test;
// short-circuit test cyclic, supply internal, passivate whole module.
`define CTRL_RST 32'h00031515
// Timing.
`define CLK_HZ 25000000
`define TICK_MS 10
`define DTIME_MIN 16'h0001
`define DTIME_MAX 16'h0BB8
`define DTIME_RST 16'h0001
`define SCT_PERIOD_MS 10
// Status bits: 0,1 discrepancy error per pair; 2 short-circuit fault.
`define ST_W 3
`define ST_SC 2
// Diagnostic entries: channel mask in the high nibble, pair in the low.
`define DIAG_P0 8'h51
`define DIAG_P1 8'hA2
`endif

// [rtl/tick_gen.v]
// Timebase divider: emits a one-cycle tick every DIV enabled cycles.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ps
module tick_gen #(
	parameter DIV = 250000
) (
	input wire clk_sys, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable
	output reg tick // one-cycle tick
);
reg [31:0] cnt_r;

always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		cnt_r <= 32'h00000000;
		tick <= 1'b0;
	end
	else if (ce)
	begin
		if (cnt_r == DIV - 1)
		begin
			cnt_r <= 32'h00000000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 32'h00000001;
			tick <= 1'b0;
		end
	end
end
endmodule // tick_gen

// [rtl/pair_eval.v]
// Evaluation of one channel pair against its discrepancy time.
// Assumes synchronised inputs, a 10 ms tick and static configuration.
`timescale 1ns/1ps
`include "disc_eval_defs.vh"
module pair_eval (
	input wire clk_sys, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable
	input wire tick, // 10 ms timebase tick
	input wire [1:0] iftype, // interconnection type
	input wire hold, // 1: hold last value, 0: force zero
	input wire ztest, // zero-signal test for reintegration
	input wire [15:0] dtime, // discrepancy time in 10 ms units
	input wire in_a, // wanted-signal channel
	input wire in_b, // partner channel
	output reg value, // evaluated value
	output reg err, // discrepancy error held
	output reg err_set // one-cycle pulse when error is declared
);
localparam S_OK = 3'b001;
localparam S_RUN = 3'b010;
localparam S_ERR = 3'b100;
reg [2:0] st_r;
reg [15:0] cnt_r;
reg last_r;
wire two_ch = (iftype == `IF_EQU) || (iftype == `IF_NEQ);
// Mismatch: same levels when nonequivalent, different levels otherwise.
wire mism = (iftype == `IF_NEQ) ? (in_a == in_b) : (in_a != in_b);
// Single channel uses a fixed shortest time.
wire [15:0] lim = two_ch ? dtime : `DTIME_MIN;
wire good = (iftype == `IF_ONE) ? in_a : in_a;
wire clr_ok = ztest ? ((iftype == `IF_NEQ) ? !in_a : (!in_a && !in_b))
	: !mism;

always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		st_r <= S_OK;
		cnt_r <= 16'h0000;
		last_r <= 1'b0;
		value <= 1'b0;
		err <= 1'b0;
		err_set <= 1'b0;
	end
	else if (ce)
	begin
		err_set <= 1'b0;
		case (st_r)
		S_OK:
		begin
			if (mism)
			begin
				st_r <= S_RUN;
				cnt_r <= 16'h0000;
				value <= hold ? last_r : 1'b0;
			end
			else
			begin
				last_r <= good;
				value <= good;
			end
		end
		S_RUN:
		begin
			if (!mism)
			begin
				st_r <= S_OK;
				last_r <= good;
				value <= good;
			end
			else if (tick && (cnt_r + 16'h0001 >= lim))
			begin
				st_r <= S_ERR;
				err <= 1'b1;
				err_set <= 1'b1;
				value <= 1'b0;
			end
			else
			begin
				if (tick)
					cnt_r <= cnt_r + 16'h0001;
				value <= hold ? last_r : 1'b0;
			end
		end
		S_ERR:
		begin
			value <= 1'b0;
			if (clr_ok)
			begin
				st_r <= S_OK;
				err <= 1'b0;
				last_r <= 1'b0;
			end
		end
		default:
			st_r <= S_OK;
		endcase
	end
end
endmodule // pair_eval

// [rtl/disc_eval_top.v]
// Overview of operation
// - The short-circuit test runs cyclically while enabled, and only with internal sensor supply selected.
// - In hold mode the value from before a discrepancy is delivered until agreement or timeout.
// - In force-zero mode the pair delivers 0 at once when a discrepancy is seen.
// - Each pair has its own discrepancy time of 10 to 30000 ms in 10 ms steps.
// - The programmed time applies only to two-channel equivalent or nonequivalent pairs.
// - The timer starts on unequal levels (equivalent) or equal levels (nonequivalent).
// - A mismatch still present when the timer expires is a discrepancy error.
// - A discrepancy error logs a diagnostic entry naming the affected channels; on a tie only pair 0 is logged.
// - With zero-signal test, an error clears only once both inputs are 0, except on nonequivalent pairs.
// - Nonequivalent with zero-signal test clears once the wanted-signal channel is 0.
// - Without zero-signal test, an error clears once the mismatch is gone.
// - Reset selects reintegration without zero-signal test.
// - Reset selects holding the last valid value.
// - A channel fault passivates the whole module or only its pair, default whole module; in pair mode a short-circuit fault passivates no pair.
//
// Top of the two-pair evaluation block with its APB register slave.
// Assumes raw sensor pins on in_ch (channel n pairs with n+2) and an APB
// master on clk_sys.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "disc_eval_defs.vh"
module disc_eval_top #(
	parameter TICK_DIV = `CLK_HZ / 1000 * `TICK_MS
) (
	input wire clk_sys, // 25 MHz system clock
	input wire rst_n, // synchronous reset, active low
	input wire ce, // clock enable, freezes all state when low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB write
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error, unmapped address
	input wire [3:0] in_ch, // sensor inputs from pins
	input wire sc_fail, // short-circuit test readback failure, pin
	output reg [1:0] value, // evaluated value per pair
	output reg sc_pulse, // short-circuit test pulse on sensor supply
	output reg irq // interrupt, level, active high
);
reg [3:0] in_s1_r;
reg [3:0] in_s2_r;
reg [1:0] sc_s1_r;
reg [1:0] sc_s2_r;
reg [31:0] ctrl_r;
reg [15:0] time0_r;
reg [15:0] time1_r;
reg [`ST_W-1:0] stat_r;
reg [`ST_W-1:0] stat_nxt;
reg [`ST_W-1:0] mask_r;
reg [7:0] diag_r;
reg [7:0] sct_cnt_r;
reg sc_flt_r;
wire tick;
wire [1:0] pv;
wire [1:0] perr;
wire [1:0] pset;
reg [31:0] rdv;
wire sct_on;
reg [1:0] pass;
wire [7:0] cfg0;
wire [7:0] cfg1;
wire addr_bad;
wire stat_wr;

// Rounds a programmed time to a 10 ms multiple and clamps to range.
function [15:0] fit_time;
	input [31:0] ms;
	reg [31:0] q;
	begin
		q = (ms + (`TICK_MS / 2)) / `TICK_MS;
		if (q < `DTIME_MIN)
			fit_time = `DTIME_MIN;
		else if (q > `DTIME_MAX)
			fit_time = `DTIME_MAX;
		else
			fit_time = q[15:0];
	end
endfunction

// Pick the control byte of a pair.
function [7:0] pair_cfg;
	input [31:0] c;
	input p;
	begin
		pair_cfg = p ? c[15:8] : c[7:0];
	end
endfunction

// An address past the last register or off a word boundary is refused.
function addr_err;
	input [11:0] a;
	begin
		addr_err = (a > `A_INPUT) || (a[1:0] != 2'h0);
	end
endfunction

// Pins come from outside the clock domain, so they pass two flops first.
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		in_s1_r <= 4'h0;
		in_s2_r <= 4'h0;
		sc_s1_r <= 2'h0;
		sc_s2_r <= 2'h0;
	end
	else if (ce)
	begin
		in_s1_r <= in_ch;
		in_s2_r <= in_s1_r;
		sc_s1_r <= {1'b0, sc_fail};
		sc_s2_r <= sc_s1_r;
	end
end

tick_gen #(
	.DIV(TICK_DIV)
) u_tick (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.ce(ce),
	.tick(tick)
);

// Channel n pairs with n+2; the lower channel carries the wanted signal.
pair_eval u_pair0 (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.ce(ce),
	.tick(tick),
	.iftype(ctrl_r[`F_IFTYPE]),
	.hold(ctrl_r[`F_HOLD]),
	.ztest(ctrl_r[`F_ZTEST]),
	.dtime(time0_r),
	.in_a(in_s2_r[0]),
	.in_b(in_s2_r[2]),
	.value(pv[0]),
	.err(perr[0]),
	.err_set(pset[0])
);

pair_eval u_pair1 (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.ce(ce),
	.tick(tick),
	.iftype(ctrl_r[`PAIR_LSB+1:`PAIR_LSB]),
	.hold(ctrl_r[`PAIR_LSB+`F_HOLD]),
	.ztest(ctrl_r[`PAIR_LSB+`F_ZTEST]),
	.dtime(time1_r),
	.in_a(in_s2_r[1]),
	.in_b(in_s2_r[3]),
	.value(pv[1]),
	.err(perr[1]),
	.err_set(pset[1])
);

// The test may only run on internal supply; external supply blocks it.
assign sct_on = ctrl_r[`F_SCT] && ctrl_r[`F_SUPINT];

// Control bytes of the two pairs, taken apart once.
assign cfg0 = pair_cfg(ctrl_r, 1'b0);
assign cfg1 = pair_cfg(ctrl_r, 1'b1);

// A channel fault is a held discrepancy error or a short-circuit fault.
// Passivating only the faulty pair keeps the healthy pair in service;
// the short-circuit fault then shows only in status, interrupt and the input register.
always @*
begin
	pass = 2'h0;
	if (ctrl_r[`F_PASSCH])
	begin
		pass[0] = perr[0];
		pass[1] = perr[1];
	end
	else
	begin
		pass[0] = |perr || sc_flt_r;
		pass[1] = |perr || sc_flt_r;
	end
	// A disabled pair always delivers 0, whatever the mode.
	if (!cfg0[`F_CHEN])
		pass[0] = 1'b1;
	if (!cfg1[`F_CHEN])
		pass[1] = 1'b1;
end

// Cyclic short-circuit test: a one-cycle dark pulse on the supply each
// period; a readback failure in that window is latched as a fault.
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		sct_cnt_r <= 8'h00;
		sc_pulse <= 1'b0;
		sc_flt_r <= 1'b0;
	end
	else if (ce)
	begin
		sc_pulse <= 1'b0;
		if (sct_on && tick)
		begin
			if (sct_cnt_r + 8'h01 >= (`SCT_PERIOD_MS / `TICK_MS))
			begin
				sct_cnt_r <= 8'h00;
				sc_pulse <= 1'b1;
			end
			else
				sct_cnt_r <= sct_cnt_r + 8'h01;
		end
		if (sc_pulse && sc_s2_r[0])
			sc_flt_r <= 1'b1;
		else if (!sct_on)
			sc_flt_r <= 1'b0;
	end
end

// A status write counts only in the cycle in which the slave takes it.
assign stat_wr = psel && penable && pwrite && !pready
	&& (paddr == `A_STAT);
assign addr_bad = addr_err(paddr);

// Sticky status: hardware set wins over a write-one clear.
always @*
begin
	stat_nxt = stat_r;
	if (stat_wr)
		stat_nxt = stat_nxt & ~pwdata[`ST_W-1:0];
	stat_nxt = stat_nxt | {(sc_pulse && sc_s2_r[0]), pset};
end

// Read multiplexer; unmapped and misaligned addresses read as 0.
always @*
begin
	rdv = 32'h00000000;
	case (paddr)
	`A_CTRL:
		rdv = ctrl_r;
	`A_TIME0:
		rdv = {16'h0000, time0_r};
	`A_TIME1:
		rdv = {16'h0000, time1_r};
	`A_STAT:
		rdv = {29'h00000000, stat_r};
	`A_MASK:
		rdv = {29'h00000000, mask_r};
	`A_DIAG:
		rdv = {24'h000000, diag_r};
	`A_INPUT:
		rdv = {24'h000000, sc_flt_r, perr, in_s2_r, 1'b0};
	default:
		rdv = 32'h00000000;
	endcase
end

// Only one entry is held: pair 0 wins a tie, since software can still
// see both pairs in the status register.
always @(posedge clk_sys)
begin
	if (!rst_n)
		diag_r <= 8'h00;
	else if (ce)
	begin
		if (pset[0])
			diag_r <= `DIAG_P0;
		else if (pset[1])
			diag_r <= `DIAG_P1;
	end
end

// Outputs to the controller and the interrupt line, all from flops.
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		value <= 2'h0;
		irq <= 1'b0;
	end
	else if (ce)
	begin
		irq <= |(stat_nxt & mask_r);
		value <= pv & ~pass;
	end
end

// APB slave: one wait state, answer in the first access cycle's next edge.
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		ctrl_r <= `CTRL_RST;
		time0_r <= `DTIME_RST;
		time1_r <= `DTIME_RST;
		stat_r <= {`ST_W{1'b0}};
		mask_r <= {`ST_W{1'b0}};
		prdata <= 32'h00000000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end
	else if (ce)
	begin
		stat_r <= stat_nxt;
		pready <= 1'b0;
		pslverr <= 1'b0;
		if (psel && penable && !pready)
		begin
			pready <= 1'b1;
			pslverr <= addr_bad;
			prdata <= rdv;
			// Read-only and refused addresses leave every register alone.
			if (pwrite && !addr_bad)
			begin
				case (paddr)
				`A_CTRL:
					ctrl_r <= pwdata;
				`A_TIME0:
					time0_r <= fit_time(pwdata);
				`A_TIME1:
					time1_r <= fit_time(pwdata);
				`A_MASK:
					mask_r <= pwdata[`ST_W-1:0];
				default:
					ctrl_r <= ctrl_r;
				endcase
			end
		end
	end
end
endmodule // disc_eval_top

// [sim/disc_eval_properties.sv]
// Port checker of the two-pair discrepancy evaluation block.
// Assumes binding to disc_eval_top on one clock.
`timescale 1ns/1ps
module disc_eval_properties #(
	parameter TICK_DIV = 10
) (
	input wire clk_sys, // clock
	input wire rst_n, // reset, low
	input wire ce, // enable
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // write
	input wire [11:0] paddr, // address
	input wire [31:0] prdata, // read data
	input wire pready, // ready
	input wire pslverr, // error
	input wire [1:0] value, // pair values
	input wire sc_pulse, // test pulse
	input wire irq // interrupt
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence taken;
		psel && penable && !pready && ce;
	endsequence
	one_wait_a: assert property (taken |=> pready)
		else $error("no answer one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (taken and paddr > 12'h018 |=> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property
		(taken and paddr <= 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returns data");
	test_gap_a: assert property (sc_pulse |=> !sc_pulse [*8])
		else $error("short-circuit pulses too close");
	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n |=> value == 2'h0 && !irq)
		else $error("outputs not quiet after reset");
	cover property (taken and paddr > 12'h018);
	cover property (irq);
	cover property ($fell(value[0]));
endmodule // disc_eval_properties

bind disc_eval_top disc_eval_properties #(.TICK_DIV(TICK_DIV))
	disc_eval_properties_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .value(value),
	.sc_pulse(sc_pulse), .irq(irq));

// [sim/safety_ctrl_model.sv]
// Stand-in for the safety controller that takes the pair values.
// Assumes the values are registered on the same clock.
`timescale 1ns/1ps
module safety_ctrl_model (
	input wire clk_sys, // clock
	input wire rst_n, // reset, low
	input wire [1:0] value, // evaluated values
	output reg [1:0] seen // values as taken
);
	// A copy every cycle: a controller that never misses a level change.
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			seen <= 2'h0;
		else
			seen <= value;
	end
endmodule // safety_ctrl_model

// [sim/dual_channel_discrepancy_eval_test.sv]
// Self-checking bench of the two-pair discrepancy evaluation block.
// Assumes the design on the include path; the tick is cut to 10 cycles.
`timescale 1ns/1ps
`include "disc_eval_defs.vh"
module dual_channel_discrepancy_eval_test;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] in_ch = 4'hF;
	reg sc_fail = 1'b0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire sc_pulse;
	wire irq;
	wire [1:0] value;
	wire [1:0] seen;
	logic [32:0] notes[$];
	int n_fail = 0;
	int n_compared = 0;
	int seed = 31;
	logic [31:0] r;
	logic [31:0] tin[4] = '{32'h18, 32'h7530, 32'h9C40, 32'h0};
	logic [31:0] tout[4] = '{32'h2, 32'hBB8, 32'hBB8, 32'h1};
	always #20 clk_sys = ~clk_sys;
	disc_eval_top #(.TICK_DIV(10)) disc_eval_top_i (.clk_sys(clk_sys),
		.rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_ch(in_ch),
		.sc_fail(sc_fail), .value(value), .sc_pulse(sc_pulse), .irq(irq));
	safety_ctrl_model safety_ctrl_model_i (.clk_sys(clk_sys),
		.rst_n(rst_n), .value(value), .seen(seen));
	task check(input logic [32:0] got, input logic [32:0] want);
		n_compared++;
		if (got !== want)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task vcheck(input logic [1:0] want);
		check({31'h0, seen}, {31'h0, want});
	endtask
	task pause(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// The request stays put until ready is seen, then one idle edge follows.
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		notes.push_back({a > 12'h018, e});
		bus(1'b0, a, 32'h0);
	endtask
	task tdone(input string s);
		$display("test %0s done", s);
	endtask
	task conclude;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		if (pready === 1'b1 && pwrite === 1'b0)
			check({pslverr, prdata}, notes.pop_front());
	end
	initial
	begin
		#400000;
		n_fail++;
		conclude();
	end
	initial
	begin
		pause(2);
		rst_n <= 1'b1;
		pause(1);
		rd(`A_CTRL, 32'h00031515);
		rd(`A_TIME0, 32'h1);
		rd(12'h01C, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(`A_TIME0, tin[i]);
			rd(`A_TIME0, tout[i]);
		end
		tdone("reset");
		wr(`A_TIME0, 32'h1E);
		wr(`A_MASK, 32'h7);
		wr(`A_CTRL, 32'h00031515);
		pause(20);
		in_ch <= 4'hB;
		pause(4);
		vcheck(2'h3);
		in_ch <= 4'hF;
		pause(20);
		in_ch <= 4'hB;
		pause(60);
		vcheck(2'h0);
		check({32'h0, irq}, 33'h1);
		rd(`A_STAT, 32'h1);
		rd(`A_DIAG, 32'h51);
		in_ch <= 4'hF;
		pause(10);
		vcheck(2'h3);
		wr(`A_STAT, 32'h1);
		pause(2);
		check({32'h0, irq}, 33'h0);
		tdone("hold");
		repeat (8)
		begin
			r = $random(seed);
			in_ch <= {r[0], 1'b1, r[0], 1'b1};
			pause(8);
			vcheck({r[0], 1'b1});
		end
		in_ch <= 4'hF;
		wr(`A_CTRL, 32'h00031511);
		pause(8);
		in_ch <= 4'hB;
		pause(7);
		vcheck(2'h2);
		tdone("zero");
		wr(`A_CTRL, 32'h0003151E);
		pause(8);
		vcheck(2'h3);
		in_ch <= 4'hF;
		pause(60);
		vcheck(2'h0);
		in_ch <= 4'hB;
		pause(10);
		vcheck(2'h0);
		in_ch <= 4'hA;
		pause(10);
		vcheck(2'h2);
		in_ch <= 4'hB;
		pause(10);
		vcheck(2'h3);
		wr(`A_STAT, 32'h7);
		tdone("reintegration");
		sc_fail <= 1'b1;
		pause(300);
		rd(`A_STAT, 32'h4);
		vcheck(2'h0);
		wr(`A_CTRL, 32'h0002151E);
		sc_fail <= 1'b0;
		wr(`A_STAT, 32'h4);
		pause(10);
		vcheck(2'h3);
		tdone("short circuit");
		conclude();
	end
endmodule // dual_channel_discrepancy_eval_test
